/* File: hw/sig_check_pkg.sv */
// Constants for the enclave signature record checker
package sig_check_pkg;
  // ****************************************
  // Record geometry and field byte offsets
  // ****************************************
  localparam int BIG_W        = 3072;
  localparam int BIG_WORDS    = 96;
  localparam int ACC_W        = 6146;
  localparam int REC_BYTES    = 1808;
  localparam int REC_WORDS    = 452;
  localparam int OFF_HEADER   = 0;
  localparam int OFF_DATE     = 20;
  localparam int OFF_SECOND_FIXED_HEADER  = 24;
  localparam int OFF_RSV0     = 44;
  localparam int OFF_MODULUS  = 128;
  localparam int OFF_EXPONENT = 512;
  localparam int OFF_SIGNATURE = 516;
  localparam int OFF_SAVE_SEL = 900;
  localparam int OFF_SAVE_MASK = 904;
  localparam int OFF_FLOW_ATTR = 908;
  localparam int OFF_FAMILY_ID = 912;
  localparam int OFF_ATTR     = 928;
  localparam int OFF_ATTR_MASK = 944;
  localparam int OFF_DIGEST   = 960;
  localparam int OFF_RSV2     = 992;
  localparam int OFF_EXT_PROD = 1008;
  localparam int OFF_PROD_ID  = 1024;
  localparam int OFF_RSV3     = 1028;
  localparam int OFF_Q1       = 1040;
  localparam int OFF_Q2       = 1424;
  localparam int SIGNED_HDR_END   = 128;
  localparam int SIGNED_BODY_BEG  = 900;
  localparam int SIGNED_BODY_END  = 1028;
  // ****************************************
  // Fixed contents, words in little-endian order
  // ****************************************
  localparam logic [127:0] HEADER_VAL =
    128'h0000_0000_0001_0000_0000_00E1_0000_0006;
  localparam logic [127:0] SECOND_FIXED_HEADER_VAL =
    128'h0000_0001_0000_0060_0000_0060_0000_0101;
  localparam logic [31:0]  EXPONENT_VAL = 32'h0000_0003;
  localparam int           PAD_FF_BYTES = 330;
  localparam logic [151:0] DIGEST_INFO =
    152'h3031_300d_0609_6086_4801_6503_0402_0105_0004_20;
  // ****************************************
  // Control registers above the record window
  // ****************************************
  localparam logic [11:0] REG_CTRL      = 12'h800;
  localparam logic [11:0] REG_STATUS    = 12'h804;
  localparam logic [11:0] REG_SAVE_CAP  = 12'h808;
  localparam logic [11:0] REG_FLOW_CAP  = 12'h80C;
  localparam logic [11:0] REG_MSG_DIG   = 12'h820;
  localparam int SB_BUSY = 0;
  localparam int SB_DONE = 1;
  localparam int SB_PASS = 2;
  localparam int SB_HDR  = 3;
  localparam int SB_RSV  = 4;
  localparam int SB_EXP  = 5;
  localparam int SB_DATE = 6;
  localparam int SB_SIG  = 7;
  localparam int SB_CAP  = 8;
  localparam int STAT_W  = 9;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SQ   = 3'b001,
    ST_SUB1 = 3'b010,
    ST_RED1 = 3'b011,
    ST_MUL2 = 3'b100,
    ST_SUB2 = 3'b101,
    ST_FIN  = 3'b110
  } check_state_t;
endpackage

/* File: hw/enclave_signature_checker.sv */
// Enclave signature record store and checker with APB access
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
module enclave_signature_checker
  import sig_check_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  output      logic        done,
  output      logic        pass
);
  // ****************************************
  // State
  // ****************************************
  logic [31:0]        rec_q [REC_WORDS];
  logic [31:0]        rec_d [REC_WORDS];
  logic [31:0]        msg_q [8];
  logic [31:0]        msg_d [8];
  logic [31:0]        save_cap_q, save_cap_d;
  logic               flow_cap_q, flow_cap_d;
  logic [STAT_W-1:0]  stat_q, stat_d;
  check_state_t       state_q, state_d;
  logic [ACC_W-1:0]   acc_q, acc_d;
  logic [ACC_W-1:0]   addend_q, addend_d;
  logic [BIG_W-1:0]   mplier_q, mplier_d;
  logic [11:0]        cnt_q, cnt_d;
  logic [31:0]        prdata_q, prdata_d;
  logic               pready_q, pready_d;
  logic               pslverr_q, pslverr_d;

  logic [BIG_W-1:0]   modulus, signature, quot1, quot2, em;
  logic [255:0]       msg_be;
  logic [8:0]         idx;
  logic               in_rec, in_msg, xfer, start_wr, last;
  logic               hdr_bad, rsv_bad, exp_bad, date_bad, cap_bad;
  logic               lt_m, any_bad;
  logic [ACC_W-1:0]   step;

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign done    = stat_q[SB_DONE];
  assign pass    = stat_q[SB_PASS];

  // ****************************************
  // Field views of the record
  // ****************************************
  // lowest word first
  for (genvar g = 0; g < BIG_WORDS; g++) begin : g_big
    assign modulus[32*g +: 32]   = rec_q[OFF_MODULUS/4 + g];
    assign signature[32*g +: 32] = rec_q[OFF_SIGNATURE/4 + g];
    assign quot1[32*g +: 32]     = rec_q[OFF_Q1/4 + g];
    assign quot2[32*g +: 32]     = rec_q[OFF_Q2/4 + g];
  end

  for (genvar b = 0; b < 32; b++) begin : g_msg
    assign msg_be[255-8*b -: 8] = msg_q[b/4][8*(b%4) +: 8];
  end

  assign em = {8'h00, 8'h01, {PAD_FF_BYTES{8'hFF}}, 8'h00,
               DIGEST_INFO, msg_be};

  // ****************************************
  // Static checks
  // ****************************************
  function automatic logic date_ok(input logic [31:0] d);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (d[4*i +: 4] > 4'h9) ok = 1'b0;
    end
    if (d[15:8] == 8'h00 || d[15:8] > 8'h12) ok = 1'b0;
    if (d[7:0] == 8'h00 || d[7:0] > 8'h31) ok = 1'b0;
    return ok;
  endfunction

  always_comb begin
    hdr_bad = {rec_q[OFF_HEADER/4+3], rec_q[OFF_HEADER/4+2],
               rec_q[OFF_HEADER/4+1], rec_q[OFF_HEADER/4]} != HEADER_VAL
           || {rec_q[OFF_SECOND_FIXED_HEADER/4+3], rec_q[OFF_SECOND_FIXED_HEADER/4+2],
               rec_q[OFF_SECOND_FIXED_HEADER/4+1], rec_q[OFF_SECOND_FIXED_HEADER/4]}
              != SECOND_FIXED_HEADER_VAL;
    rsv_bad = rec_q[OFF_FLOW_ATTR/4][31:16] != 16'h0000;
    for (int w = OFF_RSV0/4; w < OFF_MODULUS/4; w++) begin
      if (rec_q[w] != 32'h0000_0000) rsv_bad = 1'b1;
    end
    for (int w = OFF_RSV2/4; w < OFF_EXT_PROD/4; w++) begin
      if (rec_q[w] != 32'h0000_0000) rsv_bad = 1'b1;
    end
    for (int w = OFF_RSV3/4; w < OFF_Q1/4; w++) begin
      if (rec_q[w] != 32'h0000_0000) rsv_bad = 1'b1;
    end
    exp_bad  = rec_q[OFF_EXPONENT/4] != EXPONENT_VAL;
    date_bad = !date_ok(rec_q[OFF_DATE/4]);
    cap_bad  = (save_cap_q == 32'h0000_0000
                && rec_q[OFF_SAVE_SEL/4] != 32'h0000_0000)
            || (!flow_cap_q && rec_q[OFF_FLOW_ATTR/4][15:0] != 16'h0000);
    any_bad  = hdr_bad | rsv_bad | exp_bad | date_bad | cap_bad;
  end

  // ****************************************
  // APB slave
  // ****************************************
  // record at page-aligned base
  assign in_rec   = paddr < 12'(REC_BYTES);
  assign idx      = paddr[10:2];
  assign in_msg   = paddr[11:5] == REG_MSG_DIG[11:5];
  // One wait state: read data is registered on the edge that raises pready; writes land on the next edge, as pready drops
  assign xfer     = psel & penable & pready_q;
  assign start_wr = xfer & pwrite & (paddr == REG_CTRL) & pwdata[0];

  always_comb begin
    rec_d      = rec_q;
    msg_d      = msg_q;
    save_cap_d = save_cap_q;
    flow_cap_d = flow_cap_q;
    pready_d   = psel & penable & ~pready_q;
    prdata_d   = 32'h0000_0000;
    pslverr_d  = 1'b0;
    if (pready_d) begin
      if (in_rec) begin
        prdata_d  = rec_q[idx];
        pslverr_d = pwrite & (state_q != ST_IDLE);
      end else if (in_msg) begin
        prdata_d = msg_q[paddr[4:2]];
      end else if (paddr == REG_STATUS) begin
        prdata_d = {{(32-STAT_W){1'b0}}, stat_q};
      end else if (paddr == REG_SAVE_CAP) begin
        prdata_d = save_cap_q;
      end else if (paddr == REG_FLOW_CAP) begin
        prdata_d = {31'h0000_0000, flow_cap_q};
      end else if (paddr != REG_CTRL) begin
        pslverr_d = 1'b1;
      end
    end
    // Writing the record mid-check would corrupt the result
    if (xfer && pwrite) begin
      if (in_rec && state_q == ST_IDLE) rec_d[idx] = pwdata;
      if (in_msg) msg_d[paddr[4:2]] = pwdata;
      if (paddr == REG_SAVE_CAP) save_cap_d = pwdata;
      if (paddr == REG_FLOW_CAP) flow_cap_d = pwdata[0];
    end
  end

  // ****************************************
  // Signature arithmetic
  // ****************************************
  // Bit-serial multiply: slow, but one adder of the full width only
  assign step = mplier_q[0] ? addend_q : '0;
  assign last = cnt_q == 12'(BIG_W - 1);
  assign lt_m = acc_q[ACC_W-1:BIG_W] == '0
             && acc_q[BIG_W-1:0] < modulus;

  always_comb begin
    state_d  = state_q;
    stat_d   = stat_q;
    acc_d    = acc_q;
    addend_d = addend_q << 1;
    mplier_d = mplier_q >> 1;
    cnt_d    = last ? 12'h000 : cnt_q + 12'h001;
    case (state_q)
      ST_IDLE: begin
        addend_d = addend_q;
        mplier_d = mplier_q;
        cnt_d    = 12'h000;
        if (start_wr) begin
          stat_d         = '0;
          stat_d[SB_HDR] = hdr_bad;
          stat_d[SB_RSV] = rsv_bad;
          stat_d[SB_EXP] = exp_bad;
          stat_d[SB_DATE] = date_bad;
          stat_d[SB_CAP] = cap_bad;
          stat_d[SB_DONE] = any_bad;
          if (!any_bad) begin
            state_d  = ST_SQ;
            acc_d    = '0;
            addend_d = ACC_W'(signature);
            mplier_d = signature;
          end
        end
      end
      ST_SQ, ST_MUL2: begin
        acc_d = acc_q + step;
        if (last) begin
          state_d  = (state_q == ST_SQ) ? ST_SUB1 : ST_SUB2;
          addend_d = ACC_W'(modulus);
          mplier_d = (state_q == ST_SQ) ? quot1 : quot2;
        end
      end
      ST_SUB1, ST_SUB2: begin
        acc_d = acc_q - step;
        if (last) state_d = (state_q == ST_SUB1) ? ST_RED1 : ST_FIN;
      end
      ST_RED1: begin
        cnt_d = 12'h000;
        if (!lt_m) begin
          stat_d[SB_SIG]  = 1'b1;
          stat_d[SB_DONE] = 1'b1;
          state_d         = ST_IDLE;
        end else begin
          acc_d    = '0;
          addend_d = ACC_W'(acc_q[BIG_W-1:0]);
          mplier_d = signature;
          state_d  = ST_MUL2;
        end
      end
      ST_FIN: begin
        cnt_d = 12'h000;
        stat_d[SB_PASS] = lt_m && acc_q[BIG_W-1:0] == em;
        stat_d[SB_SIG]  = !(lt_m && acc_q[BIG_W-1:0] == em);
        stat_d[SB_DONE] = 1'b1;
        state_d         = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    stat_d[SB_BUSY] = state_d != ST_IDLE;
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < REC_WORDS; i++) rec_q[i] <= '0;
      for (int i = 0; i < 8; i++) msg_q[i] <= '0;
      save_cap_q <= '0;
      flow_cap_q <= 1'b0;
      stat_q     <= '0;
      state_q    <= ST_IDLE;
      acc_q      <= '0;
      addend_q   <= '0;
      mplier_q   <= '0;
      cnt_q      <= '0;
      prdata_q   <= '0;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
    end else if (ce) begin
      rec_q      <= rec_d;
      msg_q      <= msg_d;
      save_cap_q <= save_cap_d;
      flow_cap_q <= flow_cap_d;
      stat_q     <= stat_d;
      state_q    <= state_d;
      acc_q      <= acc_d;
      addend_q   <= addend_d;
      mplier_q   <= mplier_d;
      cnt_q      <= cnt_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_HDR_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_q == ST_IDLE && start_wr && hdr_bad)
      |=> stat_q[SB_HDR] && done && state_q == ST_IDLE)
    else $error("header mismatch not flagged");
  AST_RSV_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_q == ST_IDLE && start_wr && rsv_bad)
      |=> stat_q[SB_RSV] && !pass)
    else $error("reserved nonzero not flagged");
  AST_EXP_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_q == ST_IDLE && start_wr
     && rec_q[OFF_EXPONENT/4] != EXPONENT_VAL) |=> stat_q[SB_EXP])
    else $error("bad exponent not flagged");
  AST_CAP_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_q == ST_IDLE && start_wr && !flow_cap_q
     && rec_q[OFF_FLOW_ATTR/4][7:0] != 8'h00) |=> stat_q[SB_CAP])
    else $error("flow bytes without capability not flagged");
  AST_START_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_q == ST_IDLE && start_wr && !any_bad)
      |=> state_q == ST_SQ && cnt_q == 12'h000 && !done)
    else $error("clean record did not start arithmetic");
  AST_PHASE_END: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_q == ST_SQ && last) |=> state_q == ST_SUB1
      && mplier_q == quot1)
    else $error("square phase did not hand over to quotient");
  AST_RED_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_q == ST_RED1 && !lt_m)
      |=> stat_q[SB_SIG] && done && !pass)
    else $error("out-of-range remainder not flagged");
  AST_FIN_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_q == ST_FIN) |=> done
      && pass == ($past(lt_m) && $past(acc_q[BIG_W-1:0]) == $past(em)))
    else $error("pass does not match final comparison");
  AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && psel && penable && !pready_q) |=> pready_q ##1 !pready_q)
    else $error("apb answer not after one wait state");
endmodule

/* File: dv/sig_record_model.sv */
// Software-side builder of the enclave signature record image
`timescale 1ns/1ps
module sig_record_model
  import sig_check_pkg::*;
();
  logic [7:0] rec [REC_BYTES];
  logic [7:0] hash [32];

  // digest word k holds hash bytes 4k..4k+3
  function automatic logic [31:0] hword(input int k);
    return {hash[4*k+3], hash[4*k+2], hash[4*k+1], hash[4*k]};
  endfunction

  // signer with s = 2^1022, m = s^3 - block
  // Chosen so q1 = 0, q2 = 1 and the cube reduces exactly to the block
  task automatic sign();
    logic [BIG_W-1:0] blk;
    logic [BIG_W-1:0] m;
    int i;
    for (i = 0; i < 32; i++) hash[i] = 8'hA0 + 8'(i);
    blk = {8'h00, 8'h01, {PAD_FF_BYTES{8'hFF}}, 8'h00, DIGEST_INFO,
           256'h0};
    for (i = 0; i < 32; i++) blk[255-8*i -: 8] = hash[i];
    // Bit 3066 is s cubed
    m = '0;
    m[3066] = 1'b1;
    m = m - blk;
    for (i = 0; i < 384; i++) begin
      rec[OFF_MODULUS + i]   = m[8*i +: 8];
      rec[OFF_SIGNATURE + i] = 8'h00;
      rec[OFF_Q1 + i]        = 8'h00;
      rec[OFF_Q2 + i]        = 8'h00;
    end
    rec[OFF_SIGNATURE + 127] = 8'h40;
    rec[OFF_Q2]              = 8'h01;
    // flow bytes allowed once the capability is set
    rec[OFF_FLOW_ATTR]     = 8'h01;
    rec[OFF_FLOW_ATTR + 1] = 8'h01;
  endtask

  function automatic logic [31:0] word(input int k);
    return {rec[4*k+3], rec[4*k+2], rec[4*k+1], rec[4*k]};
  endfunction

  // record placed at window base, page aligned
  task automatic build();
    int i;
    for (i = 0; i < REC_BYTES; i++) rec[i] = 8'h00;
    for (i = 0; i < 16; i++) begin
      rec[OFF_HEADER + i]  = HEADER_VAL[8*i +: 8];
      rec[OFF_SECOND_FIXED_HEADER + i] = SECOND_FIXED_HEADER_VAL[8*i +: 8];
    end
    rec[OFF_DATE]     = 8'h15;
    rec[OFF_DATE + 1] = 8'h03;
    rec[OFF_DATE + 2] = 8'h24;
    rec[OFF_DATE + 3] = 8'h20;
    rec[OFF_EXPONENT] = 8'h03;
    rec[OFF_MODULUS]       = 8'h01;
    rec[OFF_MODULUS + 383] = 8'hC5;
    // select nonzero only with capability word set
    rec[OFF_SAVE_SEL] = 8'h01;
    for (i = 0; i < 32; i++) rec[OFF_DIGEST + i] = 8'(i + 1);
    rec[OFF_PROD_ID]     = 8'h34;
    rec[OFF_PROD_ID + 3] = 8'h07;
  endtask
endmodule

/* File: dv/enclave_signature_checker_tb.sv */
// Self-checking bench for the enclave signature record checker
`timescale 1ns/1ps
module enclave_signature_checker_tb
  import sig_check_pkg::*;
();
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        done;
  logic        pass;
  logic [31:0] rd;
  logic [31:0] st;
  logic        e;
  int          failures;
  int          checks;
  int          i;
  logic [11:0] t_addr [10] = '{12'h000, 12'h018, 12'h030, 12'h200,
    12'h014, 12'h014, 12'h808, 12'h38C, 12'h38C, 12'h404};
  logic [31:0] t_bad [10] = '{32'h0000_0007, 32'h0000_0100,
    32'h0000_0001, 32'h0000_0005, 32'h2024_1315, 32'h2024_0300,
    32'h0000_0000, 32'h0000_0001, 32'h0000_0100, 32'h0001_0000};
  int          t_bit [10] = '{SB_HDR, SB_HDR, SB_RSV, SB_EXP, SB_DATE,
    SB_DATE, SB_CAP, SB_CAP, SB_CAP, SB_RSV};

  sig_record_model model ();

  enclave_signature_checker dut (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .done    (done),
    .pass    (pass)
  );

  // ****************************************
  // Clock and report
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask

  task automatic timeout();
    failures++;
    $display("unexpected at %0t: wait ran out", $time);
    results();
  endtask

  // ****************************************
  // APB master, one idle cycle after each transfer
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) timeout();
    r = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Poll STATUS; a clean check runs for over twelve thousand cycles
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0000_0000, st, e);
      n++;
    end while (st[SB_DONE] !== 1'b1 && n < 5000);
    if (n >= 5000) timeout();
  endtask

  initial begin
    failures = 0;
    checks   = 0;
    presetn  = 1'b0;
    ce       = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0000_0000, rd, e);
    chk(rd, 32'h0000_0000, "status after reset");
    chk(32'(done), 32'h0000_0000, "done after reset");
    apb(1'b0, 12'h900, 32'h0000_0000, rd, e);
    chk(rd, 32'h0000_0000, "unmapped data");
    chk(32'(e), 32'h0000_0001, "unmapped error");
    // ****************************************
    // Load record and read fields back
    // ****************************************
    model.build();
    for (i = 0; i < REC_WORDS; i++) apb(1'b1, 12'(4 * i), model.word(i), rd, e);
    apb(1'b1, REG_SAVE_CAP, 32'h0000_0001, rd, e);
    for (i = 0; i < 10; i++) begin
      apb(1'b0, 12'(45 * 4 * i), 32'h0000_0000, rd, e);
      chk(rd, model.word(45 * i), "record readback");
    end
    apb(1'b0, 12'd960, 32'h0000_0000, rd, e);
    chk(rd, 32'h0403_0201, "digest word order");
    apb(1'b0, 12'd508, 32'h0000_0000, rd, e);
    chk(rd, 32'hC500_0000, "modulus top byte");
    // ****************************************
    // Clean record, zero signature fails the arithmetic
    // ****************************************
    apb(1'b1, REG_CTRL, 32'h0000_0001, rd, e);
    apb(1'b0, REG_STATUS, 32'h0000_0000, rd, e);
    chk(rd, 32'h0000_0001, "busy after start");
    // Record writes are refused while the check runs
    apb(1'b1, 12'h000, 32'h0000_0000, rd, e);
    chk(32'(e), 32'h0000_0001, "write while busy");
    wait_done();
    chk(st, 32'h0000_0082, "signature failure");
    chk(32'(pass), 32'h0000_0000, "pass port");
    chk(32'(done), 32'h0000_0001, "done port");
    apb(1'b0, 12'h000, 32'h0000_0000, rd, e);
    chk(rd, model.word(0), "record kept");
    // ****************************************
    // One corrupted field, or cleared save capability, per run
    // ****************************************
    for (i = 0; i < 10; i++) begin
      apb(1'b1, t_addr[i], t_bad[i], rd, e);
      apb(1'b1, REG_CTRL, 32'h0000_0001, rd, e);
      wait_done();
      chk(st, 32'h0000_0002 | (32'h0000_0001 << t_bit[i]), "static error");
      apb(1'b1, t_addr[i], (t_addr[i] == REG_SAVE_CAP) ? 32'h0000_0001
          : model.word(int'(t_addr[i][11:2])), rd, e);
    end
    // STATUS is read-only
    apb(1'b1, REG_STATUS, 32'hFFFF_FFFF, rd, e);
    apb(1'b0, REG_STATUS, 32'h0000_0000, rd, e);
    chk(rd, st, "status read-only");
    // ****************************************
    // Signed record with flow capability passes
    // ****************************************
    model.sign();
    for (i = 0; i < REC_WORDS; i++) begin
      apb(1'b1, 12'(4 * i), model.word(i), rd, e);
    end
    for (i = 0; i < 8; i++) begin
      apb(1'b1, REG_MSG_DIG + 12'(4 * i), model.hword(i), rd, e);
    end
    apb(1'b1, REG_FLOW_CAP, 32'h0000_0001, rd, e);
    apb(1'b0, REG_MSG_DIG + 12'h01C, 32'h0000_0000, rd, e);
    chk(rd, model.hword(7), "digest register");
    apb(1'b0, REG_FLOW_CAP, 32'h0000_0000, rd, e);
    chk(rd, 32'h0000_0001, "flow capability");
    apb(1'b1, REG_CTRL, 32'h0000_0001, rd, e);
    // Enable low longer than a whole run must leave the check busy
    ce <= 1'b0;
    repeat (13000) @(posedge pclk);
    ce <= 1'b1;
    @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0000_0000, rd, e);
    chk(rd, 32'h0000_0001, "frozen while enable low");
    wait_done();
    chk(st, 32'h0000_0006, "signature pass");
    chk(32'(pass), 32'h0000_0001, "pass port high");
    results();
  end
endmodule
